// ===== rtl/sbs_consts.svh
// Overview of operation
// - torque mode disable with braking option: stage off, brake on together
// - speed mode stop sequence needs braking option
// - ramp velocity command down at brake rate
// - decel timer starts with the ramp
// - zero speed or timeout engages brake, starts delay
// - polarity input selects brake output level, except in reset, which holds the pin at 1
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_TICK_US 1
`define SBS_CLK_MHZ 40
`define SBS_TICK_CYCLES (`SBS_TICK_US * `SBS_CLK_MHZ)
`define SBS_VEL_RESET 16'h0000
`define SBS_PIN_RESET 1'h1
`endif

// ===== rtl/sbs_pkg.sv
package sbs_pkg;
    typedef enum logic [2:0] {
        SBS_RUN,
        SBS_RAMP,
        SBS_HOLD,
        SBS_OFF
    } sbs_state_type;
endpackage : sbs_pkg

// ===== rtl/sbs_tick_if.sv
`timescale 1ns/100ps
interface sbs_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : sbs_tick_if

// ===== rtl/sbs_timebase.sv
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_timebase #(
    parameter int TICK_CYCLES = `SBS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    sbs_tick_if.src tb
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == 16'(TICK_CYCLES - 1)) begin
            cnt_next = 16'h0000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign tb.tick = tick_reg;
endmodule : sbs_timebase

// ===== rtl/sbs_sequencer.sv
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_sequencer
    import sbs_pkg::*;
#(
    parameter int VW = 16,
    parameter int TW = 16,
    parameter int TICK_CYCLES = `SBS_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic drive_enable,
    input wire logic velocity_mode,
    input wire logic braking_enable,
    input wire logic brake_output_active_high,
    input wire logic signed [VW-1:0] velocity_cmd_in,
    input wire logic signed [VW-1:0] velocity_meas,
    input wire logic [VW-1:0] brake_decel_step,
    input wire logic [VW-1:0] zero_speed_window,
    input wire logic [TW-1:0] max_decel_time,
    input wire logic [TW-1:0] pwm_disable_delay,
    output logic power_stage_on,
    output logic brake_pin,
    output logic signed [VW-1:0] velocity_cmd_out,
    output logic stop_busy
);
    sbs_tick_if tb_if ();
    sbs_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
        .ref_clk(ref_clk),
        .rst(rst),
        .tb(tb_if)
    );

    sbs_state_type st_reg, st_next;
    logic [TW-1:0] tmr_reg, tmr_next;
    logic signed [VW-1:0] vel_reg, vel_next;
    logic pwr_reg, pwr_next;
    logic brk_reg, brk_next;
    logic pin_reg, pin_next;
    logic busy_reg, busy_next;
    logic en_prev_reg;
    logic zero_speed;

    function automatic logic [VW-1:0] abs_val(input logic signed [VW-1:0] v);
        abs_val = v[VW-1] ? VW'(-v) : VW'(v);
    endfunction : abs_val

    // move value toward zero by step without overshoot
    function automatic logic signed [VW-1:0] ramp(input logic signed [VW-1:0] v, input logic [VW-1:0] s);
        if (abs_val(v) <= s) ramp = '0;
        else if (v[VW-1]) ramp = VW'(v + $signed(s));
        else ramp = VW'(v - $signed(s));
    endfunction : ramp

    // saturate so a very long delay never wraps back to zero
    function automatic logic [TW-1:0] tick_inc(input logic [TW-1:0] t, input logic tk);
        if (tk && t != '1) tick_inc = TW'(t + 1'h1);
        else tick_inc = t;
    endfunction : tick_inc

    assign zero_speed = abs_val(velocity_meas) <= zero_speed_window;

    always_comb begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        vel_next = vel_reg;
        pwr_next = pwr_reg;
        brk_next = brk_reg;
        case (st_reg)
            SBS_RUN: begin
                vel_next = velocity_cmd_in;
                tmr_next = '0;
                brk_next = 1'b0;
                pwr_next = drive_enable;
                if (!drive_enable && pwr_reg) begin
                    // sequence only with braking in speed mode
                    if (velocity_mode && braking_enable) begin
                        st_next = SBS_RAMP;
                        pwr_next = 1'b1;
                        vel_next = ramp(vel_reg, brake_decel_step);
                    end else if (braking_enable) begin
                        // stage off and brake on together
                        brk_next = 1'b1;
                        st_next = SBS_OFF;
                    end
                end else if (!drive_enable) begin
                    brk_next = braking_enable;
                end
            end
            SBS_RAMP: begin
                vel_next = ramp(vel_reg, brake_decel_step);
                tmr_next = tick_inc(tmr_reg, tb_if.tick);
                // first of zero speed or timeout
                if (zero_speed || tmr_reg >= max_decel_time) begin
                    brk_next = 1'b1;
                    tmr_next = '0;
                    st_next = SBS_HOLD;
                end
                else begin
                    brk_next = 1'b0;
                end
            end
            SBS_HOLD: begin
                vel_next = '0;
                tmr_next = tick_inc(tmr_reg, tb_if.tick);
                if (tmr_reg >= pwm_disable_delay) begin
                    pwr_next = 1'b0;
                    st_next = SBS_OFF;
                end
            end
            SBS_OFF: begin
                vel_next = '0;
                pwr_next = 1'b0;
                tmr_next = '0;
                if (drive_enable && !en_prev_reg) begin
                    st_next = SBS_RUN;
                    brk_next = 1'b0;
                    pwr_next = 1'b1;
                end
            end
            default: st_next = SBS_RUN;
        endcase
        pin_next = brake_output_active_high ? brk_next : !brk_next;
        busy_next = (st_next == SBS_RAMP) || (st_next == SBS_HOLD);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= SBS_RUN;
            tmr_reg <= '0;
            vel_reg <= `SBS_VEL_RESET;
            pwr_reg <= 1'b0;
            brk_reg <= 1'b0;
            pin_reg <= `SBS_PIN_RESET;
            busy_reg <= 1'b0;
            en_prev_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            vel_reg <= vel_next;
            pwr_reg <= pwr_next;
            brk_reg <= brk_next;
            pin_reg <= pin_next;
            busy_reg <= busy_next;
            en_prev_reg <= drive_enable;
        end
    end

    assign power_stage_on = pwr_reg;
    assign brake_pin = pin_reg;
    assign velocity_cmd_out = vel_reg;
    assign stop_busy = busy_reg;

    chk_torque_stop: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_RUN && pwr_reg && !drive_enable && !velocity_mode && braking_enable
        |=> !pwr_reg && brk_reg) else $error("torque stop not simultaneous");
    chk_seq_entry: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(busy_reg) |-> $past(velocity_mode) && $past(braking_enable)) else $error("bad sequence entry");
    chk_ramp_brake: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_RAMP |-> !brk_reg && pwr_reg) else $error("brake during ramp");
    chk_zero_brake: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_RAMP && zero_speed |=> brk_reg && st_reg == SBS_HOLD) else $error("brake not engaged");
    chk_delay_hold: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_HOLD && tmr_reg < pwm_disable_delay |=> pwr_reg) else $error("stage dropped early");
    chk_pin_pol: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> pin_reg == ($past(brake_output_active_high) ~^ brk_reg))
        else $error("brake pin polarity wrong");
    chk_ramp_down: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_RAMP && $past(st_reg) == SBS_RAMP |-> abs_val(vel_reg) <= abs_val($past(vel_reg)))
        else $error("ramp not decreasing");
    chk_timer_clr: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_OFF |=> tmr_reg == '0) else $error("timer not cleared");

    // stop sequence steps
    sequence seq_ramp_start;
        st_reg == SBS_RUN && pwr_reg && !drive_enable && velocity_mode && braking_enable;
    endsequence
    sequence seq_ramp_begun;
        st_reg == SBS_RAMP && busy_reg && pwr_reg && tmr_reg == '0;
    endsequence
    sequence seq_hold_begun;
        st_reg == SBS_HOLD && busy_reg && brk_reg && pwr_reg && tmr_reg == '0;
    endsequence
    chk_ramp_entry: assert property (@(posedge ref_clk) disable iff (rst)
        seq_ramp_start |=> seq_ramp_begun)
        else $error("ramp entry without cleared timer");
    chk_timeout_brake: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_RAMP && tmr_reg >= max_decel_time |=> seq_hold_begun)
        else $error("timeout did not engage brake");
    chk_delay_off: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_HOLD && tmr_reg >= pwm_disable_delay |=> st_reg == SBS_OFF && !pwr_reg && brk_reg)
        else $error("stage not off after delay");
    chk_off_hold: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_OFF && !(drive_enable && !en_prev_reg) |=> st_reg == SBS_OFF && !pwr_reg)
        else $error("drive left off state without enable edge");
    chk_reenable_run: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_OFF && drive_enable && !en_prev_reg |=> st_reg == SBS_RUN && pwr_reg && !brk_reg && tmr_reg == '0)
        else $error("re-enable did not restart drive");
    chk_tick_count: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_HOLD && $past(st_reg) == SBS_HOLD |-> tmr_reg == ($past(tb_if.tick) ? $past(tmr_reg) + 1'h1 : $past(tmr_reg)))
        else $error("delay timer not counting ticks");
    chk_plain_stop: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg == SBS_RUN && pwr_reg && !drive_enable && !braking_enable |=> st_reg == SBS_RUN && !pwr_reg && !busy_reg)
        else $error("sequence started without braking option");
endmodule : sbs_sequencer

// ===== tb/sbs_host_model.sv
`timescale 1ns/100ps
module sbs_host_model (
    input wire logic ref_clk,
    input wire logic want_en,
    output logic drive_enable
);
    initial drive_enable = 1'h0;
    // host moves its request off the sampling edge
    always @(negedge ref_clk) begin
        drive_enable <= want_en;
    end
endmodule : sbs_host_model

// ===== tb/sbs_sequencer_tb.sv
`timescale 1ns/100ps
module sbs_sequencer_tb;
    logic ref_clk, rst, want_en, drive_enable, vm, be, pol, pwr, brk, busy;
    logic signed [15:0] vcmd, vmeas, vout;
    logic [15:0] win, tmax, tdly, step;
    logic [2:0] note_q[$];
    int miscompares = 0;
    int check_count = 0;
    int n;
    sbs_host_model i_sbs_host_model (.ref_clk(ref_clk), .want_en(want_en), .drive_enable(drive_enable));
    sbs_sequencer #(.TICK_CYCLES(2)) i_sbs_sequencer (.ref_clk(ref_clk), .rst(rst), .drive_enable(drive_enable),
        .velocity_mode(vm), .braking_enable(be), .brake_output_active_high(pol), .velocity_cmd_in(vcmd),
        .velocity_meas(vmeas), .brake_decel_step(step), .zero_speed_window(win), .max_decel_time(tmax),
        .pwm_disable_delay(tdly), .power_stage_on(pwr), .brake_pin(brk), .velocity_cmd_out(vout),
        .stop_busy(busy));
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        if (note_q.size() != 0) miscompares++;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    task note(input logic [2:0] e);
        note_q.push_back(e);
        @(negedge ref_clk);
    endtask : note
    task set_en(input logic v);
        @(posedge ref_clk);
        want_en = v;
        @(negedge ref_clk);
    endtask : set_en
    // bounded wait; a hang ends the run
    task wait_out(input logic [2:0] t);
        n = 0;
        while ({pwr, brk, busy} !== t && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300) begin
            miscompares++;
            close_out();
        end
    endtask : wait_out
    // oldest note against the outputs settled before this edge
    always @(posedge ref_clk) begin
        if (note_q.size() > 0) check({pwr, brk, busy}, note_q.pop_front());
    end
    initial begin
        void'($urandom(32'h091f));
        step = 16'($urandom_range(16'h0100, 16'h0001));
        rst = 1'h1;
        want_en = 1'h0;
        vm = 1'h0;
        be = 1'h1;
        pol = 1'h0;
        vcmd = 16'h0000;
        vmeas = 16'h0000;
        win = 16'h0020;
        tmax = 16'hff00;
        tdly = 16'h0003;
        repeat (3) @(negedge ref_clk);
        note(3'h2);
        rst = 1'h0;
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            set_en(1'h1);
            repeat (3) @(negedge ref_clk);
            note({1'h1, ~pol, 1'h0});
            set_en(1'h0);
            note({1'h1, ~pol, 1'h0});
            note({1'h0, pol, 1'h0});
        end
        vm = 1'h1;
        pol = 1'h0;
        vcmd = 16'($urandom_range(16'h7000, 16'h1000));
        vmeas = vcmd;
        set_en(1'h1);
        repeat (3) @(negedge ref_clk);
        set_en(1'h0);
        repeat (4) @(negedge ref_clk);
        check(vout, 16'(vcmd - 4 * step));
        note(3'h7);
        // window edge, negative side, counts as stopped
        vmeas = -$signed(win);
        wait_out(3'h5);
        check({2'h0, n < 2}, 3'h1);
        wait_out(3'h0);
        check({2'h0, n >= 5 && n <= 8}, 3'h1);
        pol = 1'h1;
        vcmd = -vcmd;
        vmeas = 16'h4000;
        tmax = 16'h0004;
        set_en(1'h1);
        repeat (3) @(negedge ref_clk);
        set_en(1'h0);
        wait_out(3'h7);
        check({2'h0, n >= 7 && n <= 11}, 3'h1);
        wait_out(3'h2);
        be = 1'h0;
        pol = 1'h0;
        set_en(1'h1);
        repeat (3) @(negedge ref_clk);
        set_en(1'h0);
        repeat (2) @(negedge ref_clk);
        note(3'h2);
        be = 1'h1;
        set_en(1'h1);
        repeat (3) @(negedge ref_clk);
        set_en(1'h0);
        repeat (2) @(negedge ref_clk);
        // reset in mid-ramp drops the stage at once
        rst = 1'h1;
        repeat (2) @(negedge ref_clk);
        note(3'h2);
        rst = 1'h0;
        note(3'h2);
        note(3'h0);
        close_out();
    end
endmodule : sbs_sequencer_tb
